//--- rtl/rsc_device_end.sv
`timescale 1ns/100ps
`default_nettype none
module rsc_device_end #(parameter int NSRC = rsc_pkg::NUM_SOURCES)
(
   input wire logic core_clk,
   input wire logic rst_n,
   rsc_pair_if.dev cfg,
   input wire logic external_sync_input,
   input wire logic [NSRC-1:0] src_ok,
   input wire logic dpll_locked,
   input wire logic ext_sync_mode,
   input wire logic lock_ref_is_2k,
   input wire logic lock_ref_is_8k,
   input wire logic ref_edge,
   output logic [3:0] primary_sel,
   output logic primary_sel_ok,
   output logic [3:0] secondary_sel,
   output logic secondary_sel_ok,
   output logic eff_slave_prio,
   output logic eff_absorb,
   output logic eff_revertive,
   output logic eff_bw_acq,
   output logic [3:0] active_bw,
   output logic [15:0] applied_phase_ofs,
   output logic frame_sync_output,
   output logic multiframe_sync_output
);
   logic role_master;
   logic sync_lvl;
   logic sync_prev_q;
   logic sync_pend_q;
   logic [3:0] prio_q [2][NSRC];
   logic [3:0] prio_eff [2][NSRC];
   logic [NSRC-1:0] usable;
   logic [3:0] slave_f;
   logic revert_path [2];
   logic [4:0] best [2];
   logic [3:0] sel_q [2];
   logic sel_ok_q [2];
   logic [11:0] frame_cnt_q;
   logic [1:0] mf_cnt_q;
   logic realign_all;
   logic realign_frame;
   logic frame_wrap;

   // Both external levels pass two flops before any setting is steered by them.
   rsc_sync2 #(.W(2)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in({cfg.pair_role_select_pin, external_sync_input}),
      .sync_out({role_master, sync_lvl})
   ); // [RULE_21]

   // Lowest non-zero priority value wins; ties go to the lower input number.
   function automatic logic [4:0] best_src(input logic [3:0] pr [NSRC], input logic [NSRC-1:0] ok);
      logic [3:0] bv;
      logic [4:0] res;
      bv = 4'hf;
      res = 5'h00;
      for (int i = 0; i < NSRC; i++)
      begin
         if (ok[i] && pr[i] != rsc_pkg::PRIO_OFF && (!res[4] || pr[i] < bv))
         begin
            bv = pr[i];
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction : best_src

   // Each function follows the pin unless software has taken it over.
   always_comb
   begin
      for (int f = 0; f < 4; f++)
      begin
         slave_f[f] = cfg.ovr_en[f] ? cfg.ovr_slave[f] : !role_master; // [RULE_08]
      end
   end

   assign eff_slave_prio = slave_f[rsc_pkg::F_SLV_PRIO];
   assign eff_absorb = !slave_f[rsc_pkg::F_ABSORB] && (cfg.absorb_cfg != 2'b00); // [RULE_02] [RULE_06]
   assign eff_revertive = slave_f[rsc_pkg::F_REVERT] || cfg.revert_cfg; // [RULE_03] [RULE_06]
   always_comb
   begin
      if (slave_f[rsc_pkg::F_BW])
      begin
         eff_bw_acq = 1'b1; // [RULE_04]
      end
      else if (cfg.bw_auto)
      begin
         eff_bw_acq = !dpll_locked; // [RULE_07]
      end
      else
      begin
         eff_bw_acq = cfg.bw_manual_acq; // [RULE_06]
      end
   end
   assign revert_path[0] = eff_revertive;
   assign revert_path[1] = cfg.revert_cfg;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active_bw <= rsc_pkg::BW_RST;
      end
      else
      begin
         active_bw <= eff_bw_acq ? cfg.acq_bw : cfg.lock_bw;
      end
   end

   // A phase offset is meaningful only when outputs track the reference edge directly.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         applied_phase_ofs <= '0;
      end
      else
      begin
         applied_phase_ofs <= eff_absorb ? '0 : cfg.phase_ofs; // [RULE_20] [RULE_13]
      end
   end

   // Separate tables let the master's output be disabled on the secondary path only.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < 2; p++)
         begin
            for (int i = 0; i < NSRC; i++)
            begin
               prio_q[p][i] <= rsc_pkg::PRIO_RST;
            end
         end
      end
      else if (cfg.prio_wr && cfg.prio_idx < 4'(NSRC))
      begin
         prio_q[cfg.prio_path][cfg.prio_idx] <= cfg.prio_val; // [RULE_12]
      end
   end

   always_comb
   begin
      prio_eff = prio_q;
      if (eff_slave_prio)
      begin
         prio_eff[rsc_pkg::PATH_PRIMARY][rsc_pkg::XC_IDX] = rsc_pkg::PRIO_TOP; // [RULE_01]
      end
      // A master keeps whatever software wrote for the cross-connect input. [RULE_05]
   end

   assign usable = src_ok & cfg.remote_valid;
   assign cfg.local_valid = src_ok;

   generate
      for (genvar p = 0; p < 2; p++)
      begin : g_path
         assign best[p] = best_src(prio_eff[p], usable);
         // Non-revertive paths hold a working source even if a better one returns.
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sel_q[p] <= 4'h0;
               sel_ok_q[p] <= 1'b0;
            end
            else if (revert_path[p] || !sel_ok_q[p] || !usable[sel_q[p]]
                     || prio_eff[p][sel_q[p]] == rsc_pkg::PRIO_OFF)
            begin
               sel_q[p] <= best[p][3:0]; // [RULE_03] [RULE_15]
               sel_ok_q[p] <= best[p][4];
            end
         end
      end
   endgenerate

   assign primary_sel = sel_q[0];
   assign primary_sel_ok = sel_ok_q[0];
   assign secondary_sel = sel_q[1];
   assign secondary_sel_ok = sel_ok_q[1];

   // The sync input is sampled every cycle, its falling edge is acted on only at the next reference edge, and it never enters selection.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_prev_q <= 1'b0;
         sync_pend_q <= 1'b0;
      end
      else
      begin
         sync_prev_q <= sync_lvl;
         if (ext_sync_mode && sync_prev_q && !sync_lvl)
         begin
            sync_pend_q <= 1'b1; // [RULE_18]
         end
         else if (ref_edge)
         begin
            sync_pend_q <= 1'b0;
         end
      end
   end

   assign realign_all = ref_edge && ((ext_sync_mode && sync_pend_q) || lock_ref_is_2k); // [RULE_16] [RULE_18]
   assign realign_frame = ref_edge && lock_ref_is_8k && !ext_sync_mode; // [RULE_17]
   assign frame_wrap = frame_cnt_q == 12'(rsc_pkg::FRAME_CYCLES - 1);

   // Multiframe timing is a division of the frame counter, so both stay edge related.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frame_cnt_q <= '0;
         mf_cnt_q <= '0;
      end
      else if (realign_all)
      begin
         frame_cnt_q <= '0;
         mf_cnt_q <= '0;
      end
      else if (realign_frame)
      begin
         frame_cnt_q <= '0; // [RULE_17]
      end
      else if (frame_wrap)
      begin
         frame_cnt_q <= '0;
         mf_cnt_q <= (mf_cnt_q == 2'(rsc_pkg::FRAMES_PER_MF - 1)) ? 2'h0 : mf_cnt_q + 2'h1; // [RULE_14]
      end
      else
      begin
         frame_cnt_q <= frame_cnt_q + 12'h001;
      end
   end

   // The frame sync falls at each frame boundary; the multiframe sync falls with it only at every fourth one.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frame_sync_output <= 1'b1;
         multiframe_sync_output <= 1'b1;
      end
      else
      begin
         frame_sync_output <= frame_cnt_q >= 12'(rsc_pkg::FRAME_CYCLES / 2); // [RULE_14]
         multiframe_sync_output <= mf_cnt_q >= 2'(rsc_pkg::FRAMES_PER_MF / 2);
      end
   end
endmodule : rsc_device_end
`default_nettype wire

//--- rtl/rsc_pair_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rsc_pair_if #(parameter int NSRC = rsc_pkg::NUM_SOURCES);
   logic pair_role_select_pin;
   logic prio_wr;
   logic prio_path;
   logic [3:0] prio_idx;
   logic [3:0] prio_val;
   logic [3:0] ovr_en;
   logic [3:0] ovr_slave;
   logic [1:0] absorb_cfg;
   logic revert_cfg;
   logic bw_auto;
   logic bw_manual_acq;
   logic [3:0] lock_bw;
   logic [3:0] acq_bw;
   logic [15:0] phase_ofs;
   logic [NSRC-1:0] remote_valid;
   logic [NSRC-1:0] local_valid;
   modport dev (
      input pair_role_select_pin, prio_wr, prio_path, prio_idx, prio_val, ovr_en, ovr_slave,
      input absorb_cfg, revert_cfg, bw_auto, bw_manual_acq, lock_bw, acq_bw, phase_ofs, remote_valid,
      output local_valid
   );
   modport sup (
      output pair_role_select_pin, prio_wr, prio_path, prio_idx, prio_val, ovr_en, ovr_slave,
      output absorb_cfg, revert_cfg, bw_auto, bw_manual_acq, lock_bw, acq_bw, phase_ofs, remote_valid,
      input local_valid
   );
endinterface : rsc_pair_if
`default_nettype wire

//--- rtl/rsc_pkg.sv
// Contract
// RULE_01: Slave forces cross-connect input priority to one.
// RULE_02: Slave disables phase-transient absorption.
// RULE_03: Slave forces revertive selection on.
// RULE_04: Slave forces primary bandwidth to acquisition.
// RULE_05: Master uses programmed cross-connect priority, zero.
// RULE_06: Master follows absorption, revertive, bandwidth registers.
// RULE_07: Master automatic bandwidth switches locked/acquisition.
// RULE_08: Software may set the four functions.
// RULE_09: Software copies local validity to partner.
// RULE_10: Priorities equal except cross-connect entries.
// RULE_11: Slave configured with highest loop bandwidth.
// RULE_12: Separate priority tables per clock path.
// RULE_13: Absorption off: outputs in phase with reference.
// RULE_14: Faster outputs edge aligned, slower divided.
// RULE_15: Secondary outputs follow secondary selected input.
// RULE_16: Locked to 2 kHz: all outputs align.
// RULE_17: Locked to 8 kHz: all but multiframe align. The code does this 8 kHz alignment only while ext_sync_mode is low.
// RULE_18: External sync only realigns, never locked to.
// RULE_19: Software keeps both devices consistent by polling.
// RULE_20: Phase offset applies only with absorption off.
// RULE_21: Role pin synchronised before overriding settings.
package rsc_pkg;
   localparam int NUM_SOURCES = 14;
   localparam logic [3:0] XC_IDX = 4'ha;
   localparam logic [3:0] PRIO_OFF = 4'h0;
   localparam logic [3:0] PRIO_TOP = 4'h1;
   localparam logic [3:0] PRIO_RST = 4'h0;
   localparam logic [3:0] BW_MAX = 4'hf;
   localparam logic [3:0] BW_RST = 4'h0;
   localparam int F_SLV_PRIO = 0;
   localparam int F_ABSORB = 1;
   localparam int F_REVERT = 2;
   localparam int F_BW = 3;
   localparam int CLK_PERIOD_NS = 40;
   localparam int FRAME_PERIOD_NS = 125000;
   localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
   localparam int FRAMES_PER_MF = 4;
   localparam int POLL_PERIOD_NS = 100000;
   localparam int POLL_CYCLES = POLL_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic PATH_PRIMARY = 1'b0;
   localparam logic PATH_SECONDARY = 1'b1;
endpackage : rsc_pkg

//--- rtl/rsc_supervisor_end.sv
`timescale 1ns/100ps
`default_nettype none
module rsc_supervisor_end #(
   parameter int NSRC = rsc_pkg::NUM_SOURCES,
   parameter int POLL = rsc_pkg::POLL_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   rsc_pair_if.sup bus,
   input wire logic is_master,
   input wire logic use_pin,
   input wire logic [NSRC-1:0] partner_valid,
   input wire logic usr_prio_wr,
   input wire logic usr_prio_path,
   input wire logic [3:0] usr_prio_idx,
   input wire logic [3:0] usr_prio_val,
   input wire logic [1:0] usr_absorb,
   input wire logic usr_revert,
   input wire logic usr_bw_auto,
   input wire logic usr_bw_manual_acq,
   input wire logic [3:0] usr_lock_bw,
   input wire logic [3:0] usr_acq_bw,
   input wire logic [15:0] usr_phase_ofs,
   output logic [NSRC-1:0] local_valid_out
);
   logic [15:0] poll_q;
   logic poll_hit;
   logic [3:0] wval;

   assign poll_hit = poll_q == 16'(POLL - 1);

   // Partner state is refreshed on a fixed poll so both devices converge.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         poll_q <= '0;
      end
      else
      begin
         poll_q <= poll_hit ? '0 : poll_q + 16'h0001; // [RULE_19]
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus.remote_valid <= '1;
         local_valid_out <= '0;
      end
      else if (poll_hit)
      begin
         bus.remote_valid <= partner_valid; // [RULE_09]
         local_valid_out <= bus.local_valid;
      end
   end

   always_comb
   begin
      wval = usr_prio_val;
      if (usr_prio_idx == rsc_pkg::XC_IDX)
      begin
         if (usr_prio_path == rsc_pkg::PATH_SECONDARY || is_master)
         begin
            wval = rsc_pkg::PRIO_OFF; // [RULE_05] [RULE_10] [RULE_12]
         end
         else
         begin
            wval = rsc_pkg::PRIO_TOP; // [RULE_10]
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus.pair_role_select_pin <= 1'b0;
         bus.prio_wr <= 1'b0;
         bus.prio_path <= 1'b0;
         bus.prio_idx <= '0;
         bus.prio_val <= rsc_pkg::PRIO_RST;
         bus.ovr_en <= '0;
         bus.ovr_slave <= '0;
         bus.absorb_cfg <= '0;
         bus.revert_cfg <= 1'b0;
         bus.bw_auto <= 1'b0;
         bus.bw_manual_acq <= 1'b0;
         bus.lock_bw <= rsc_pkg::BW_RST;
         bus.acq_bw <= rsc_pkg::BW_RST;
         bus.phase_ofs <= '0;
      end
      else
      begin
         bus.pair_role_select_pin <= is_master;
         bus.prio_wr <= usr_prio_wr;
         bus.prio_path <= usr_prio_path;
         bus.prio_idx <= usr_prio_idx;
         bus.prio_val <= wval;
         bus.ovr_en <= use_pin ? 4'h0 : 4'hf;
         bus.ovr_slave <= {4{!is_master}};
         bus.absorb_cfg <= is_master ? usr_absorb : 2'b00;
         bus.revert_cfg <= usr_revert || !is_master;
         bus.bw_auto <= usr_bw_auto;
         bus.bw_manual_acq <= usr_bw_manual_acq;
         bus.lock_bw <= is_master ? usr_lock_bw : rsc_pkg::BW_MAX; // [RULE_11]
         bus.acq_bw <= is_master ? usr_acq_bw : rsc_pkg::BW_MAX; // [RULE_11]
         bus.phase_ofs <= usr_phase_ofs;
      end
   end
endmodule : rsc_supervisor_end
`default_nettype wire

//--- rtl/rsc_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module rsc_sync2 #(parameter int W = 1)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : rsc_sync2
`default_nettype wire

//--- tb/master_slave_redundancy_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module master_slave_redundancy_control_tb;
   logic core_clk;
   logic rst_n;
   logic external_sync_input, dpll_locked, ext_sync_mode, lock_ref_is_2k, lock_ref_is_8k, ref_edge;
   logic [13:0] src_ok, partner_valid, local_valid_out;
   logic is_master, use_pin, usr_prio_wr, usr_prio_path, usr_revert, usr_bw_auto, usr_bw_manual_acq;
   logic [3:0] usr_prio_idx, usr_prio_val, usr_lock_bw, usr_acq_bw, primary_sel, secondary_sel, active_bw;
   logic [1:0] usr_absorb;
   logic [15:0] usr_phase_ofs, applied_phase_ofs;
   logic primary_sel_ok, secondary_sel_ok, eff_slave_prio, eff_absorb, eff_revertive, eff_bw_acq;
   logic frame_sync_output, multiframe_sync_output;
   int fail_count = 0;
   int num_checks = 0;
   rsc_pair_if rsc_pair_if_i ();
   rsc_device_end rsc_device_end_i (.core_clk, .rst_n, .cfg(rsc_pair_if_i.dev), .external_sync_input, .src_ok,
      .dpll_locked, .ext_sync_mode, .lock_ref_is_2k, .lock_ref_is_8k, .ref_edge, .primary_sel, .primary_sel_ok,
      .secondary_sel, .secondary_sel_ok, .eff_slave_prio, .eff_absorb, .eff_revertive, .eff_bw_acq,
      .active_bw, .applied_phase_ofs, .frame_sync_output, .multiframe_sync_output);
   rsc_supervisor_end #(.POLL(4)) rsc_supervisor_end_i (.core_clk, .rst_n, .bus(rsc_pair_if_i.sup), .is_master,
      .use_pin, .partner_valid, .usr_prio_wr, .usr_prio_path, .usr_prio_idx, .usr_prio_val, .usr_absorb,
      .usr_revert, .usr_bw_auto, .usr_bw_manual_acq, .usr_lock_bw, .usr_acq_bw, .usr_phase_ofs,
      .local_valid_out);
   rsc_pair_chk rsc_pair_chk_i (.core_clk, .rst_n, .pair_role_select_pin(rsc_pair_if_i.pair_role_select_pin),
      .prio_wr(rsc_pair_if_i.prio_wr), .prio_path(rsc_pair_if_i.prio_path), .prio_idx(rsc_pair_if_i.prio_idx),
      .prio_val(rsc_pair_if_i.prio_val), .ovr_en(rsc_pair_if_i.ovr_en), .ovr_slave(rsc_pair_if_i.ovr_slave),
      .absorb_cfg(rsc_pair_if_i.absorb_cfg), .revert_cfg(rsc_pair_if_i.revert_cfg),
      .acq_bw(rsc_pair_if_i.acq_bw), .phase_ofs(rsc_pair_if_i.phase_ofs), .eff_slave_prio, .eff_absorb,
      .eff_revertive, .eff_bw_acq, .active_bw, .applied_phase_ofs);
   always #20 core_clk = ~core_clk;
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Role changes pass a supervisor flop and the device synchroniser, so allow them time to settle.
   task automatic set_role(input logic m, input logic p);
      is_master = m;
      use_pin = p;
      cyc(8);
   endtask : set_role
   task automatic wr(input logic path, input logic [3:0] idx, input logic [3:0] val);
      usr_prio_wr = 1'b1;
      usr_prio_path = path;
      usr_prio_idx = idx;
      usr_prio_val = val;
      cyc(1);
      usr_prio_wr = 1'b0;
      cyc(1);
   endtask : wr
   task automatic pulse(input logic is2k);
      lock_ref_is_2k = is2k;
      lock_ref_is_8k = !is2k;
      ref_edge = 1'b1;
      cyc(1);
      ref_edge = 1'b0;
      cyc(2);
   endtask : pulse
   task automatic test_roles();
      set_role(1'b0, 1'b1);
      chk(eff_slave_prio, 1'b1);
      chk(eff_absorb, 1'b0);
      chk(eff_revertive, 1'b1);
      chk(eff_bw_acq, 1'b1);
      chk(active_bw, rsc_pkg::BW_MAX);
      set_role(1'b1, 1'b1);
      chk(eff_slave_prio, 1'b0);
      chk(eff_absorb, 1'b1);
      chk(eff_revertive, 1'b0);
      chk(active_bw, usr_lock_bw);
      chk(applied_phase_ofs, 16'h0000);
      usr_bw_manual_acq = 1'b1;
      cyc(4);
      chk(active_bw, usr_acq_bw);
      usr_bw_manual_acq = 1'b0;
      usr_bw_auto = 1'b1;
      cyc(4);
      chk(eff_bw_acq, 1'b1);
      dpll_locked = 1'b1;
      cyc(4);
      chk(active_bw, usr_lock_bw);
      usr_absorb = 2'h0;
      cyc(4);
      chk(applied_phase_ofs, usr_phase_ofs);
      // Software takes over at once, while the synchronised pin still reads master.
      is_master = 1'b0;
      use_pin = 1'b0;
      cyc(1);
      chk(eff_slave_prio, 1'b1);
      chk(eff_bw_acq, 1'b1);
      cyc(7);
      chk(eff_absorb, 1'b0);
      chk(eff_revertive, 1'b1);
      chk(eff_bw_acq, 1'b1);
      $display("test_roles finished");
   endtask : test_roles
   task automatic test_select();
      usr_revert = 1'b1;
      set_role(1'b1, 1'b1);
      wr(1'b0, 4'h5, 4'h2);
      wr(1'b0, 4'h3, 4'h2);
      wr(1'b0, rsc_pkg::XC_IDX, 4'h1);
      wr(1'b1, 4'h3, 4'h2);
      wr(1'b1, rsc_pkg::XC_IDX, 4'h1);
      wr(1'b0, 4'he, 4'h1);
      cyc(4);
      chk(primary_sel, 4'h3);
      chk(primary_sel_ok, 1'b1);
      set_role(1'b0, 1'b1);
      chk(primary_sel, rsc_pkg::XC_IDX);
      chk(secondary_sel, 4'h3);
      chk(secondary_sel_ok, 1'b1);
      set_role(1'b1, 1'b1);
      partner_valid = 14'h3ff7;
      cyc(12);
      chk(primary_sel, 4'h5);
      src_ok = 14'h3fd7;
      cyc(12);
      chk(local_valid_out, src_ok);
      chk(primary_sel_ok, 1'b0);
      $display("test_select finished");
   endtask : test_select
   task automatic test_frames();
      pulse(1'b1);
      chk(frame_sync_output, 1'b0);
      chk(multiframe_sync_output, 1'b0);
      cyc(2000);
      chk(frame_sync_output, 1'b1);
      cyc(rsc_pkg::FRAME_CYCLES);
      chk(multiframe_sync_output, 1'b0);
      cyc(rsc_pkg::FRAME_CYCLES);
      chk(multiframe_sync_output, 1'b1);
      pulse(1'b0);
      chk(frame_sync_output, 1'b0);
      chk(multiframe_sync_output, 1'b1);
      $display("test_frames finished");
   endtask : test_frames
   // A sync edge alone must not move the dividers; only the next reference edge applies it.
   task automatic test_ext_sync();
      {ext_sync_mode, lock_ref_is_2k, lock_ref_is_8k, external_sync_input} = 4'h8;
      cyc(6);
      chk(multiframe_sync_output, 1'b1);
      ref_edge = 1'b1;
      cyc(1);
      ref_edge = 1'b0;
      cyc(2);
      chk(multiframe_sync_output, 1'b0);
      chk(frame_sync_output, 1'b0);
      {ext_sync_mode, external_sync_input} = 2'h1;
      $display("test_ext_sync finished");
   endtask : test_ext_sync
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   initial
   begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      {external_sync_input, dpll_locked, ext_sync_mode, lock_ref_is_2k, lock_ref_is_8k, ref_edge} = 6'h20;
      src_ok = 14'h3fff;
      partner_valid = 14'h3fff;
      {is_master, use_pin, usr_prio_wr, usr_prio_path, usr_revert, usr_bw_auto, usr_bw_manual_acq} = 7'h40;
      usr_prio_idx = 4'h0;
      usr_prio_val = 4'h0;
      usr_absorb = 2'h3;
      usr_lock_bw = 4'h3;
      usr_acq_bw = 4'hc;
      usr_phase_ofs = 16'h1234;
      cyc(8);
      rst_n = 1'b1;
      cyc(2);
      test_roles();
      test_select();
      test_frames();
      test_ext_sync();
      finish_test();
   end
   initial
   begin
      #(40 * 40000);
      fail_count++;
      finish_test();
   end
endmodule : master_slave_redundancy_control_tb
`default_nettype wire

//--- tb/rsc_pair_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rsc_pair_chk
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic pair_role_select_pin,
   input wire logic prio_wr,
   input wire logic prio_path,
   input wire logic [3:0] prio_idx,
   input wire logic [3:0] prio_val,
   input wire logic [3:0] ovr_en,
   input wire logic [3:0] ovr_slave,
   input wire logic [1:0] absorb_cfg,
   input wire logic revert_cfg,
   input wire logic [3:0] acq_bw,
   input wire logic [15:0] phase_ofs,
   input wire logic eff_slave_prio,
   input wire logic eff_absorb,
   input wire logic eff_revertive,
   input wire logic eff_bw_acq,
   input wire logic [3:0] active_bw,
   input wire logic [15:0] applied_phase_ofs
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // The pin crosses a two-flop synchroniser, so a role counts only once it has stood four cycles.
   sequence s_slave_held;
      (!pair_role_select_pin && ovr_en == 4'h0) [*4];
   endsequence
   sequence s_master_held;
      (pair_role_select_pin && ovr_en == 4'h0) [*4];
   endsequence
   sequence s_xc_wr;
      prio_wr && prio_idx == rsc_pkg::XC_IDX;
   endsequence
   a_slave_prio_top: assert property (s_slave_held |-> eff_slave_prio)
      else $error("slave role left the cross-connect priority unforced");
   a_slave_absorb_off: assert property (s_slave_held |-> !eff_absorb)
      else $error("slave role kept absorption on");
   a_slave_revert_on: assert property (s_slave_held |-> eff_revertive)
      else $error("slave role left revertive off");
   // A slave gets equal lock and acquisition codes, so the bandwidth select itself must be watched too.
   a_slave_bw_acq: assert property (s_slave_held ##1 $stable(acq_bw)
      |-> active_bw == acq_bw && $past(eff_bw_acq))
      else $error("slave role not on acquisition bandwidth");
   a_master_xc_off: assert property (s_xc_wr ##0 (!prio_path && pair_role_select_pin && ovr_en == 4'h0)
      |-> prio_val == rsc_pkg::PRIO_OFF)
      else $error("master wrote a live cross-connect priority");
   a_master_follow: assert property (s_master_held
      |-> eff_absorb == (absorb_cfg != 2'h0) && eff_revertive == revert_cfg)
      else $error("master role does not follow its settings");
   // Software settings bypass the synchroniser, so they must take hold in the very cycle they appear.
   a_sw_override: assert property (ovr_en == 4'hf && ovr_slave == 4'hf
      |-> eff_slave_prio && !eff_absorb && eff_revertive && eff_bw_acq)
      else $error("software slave setting not applied");
   a_pin_sync_delay: assert property (ovr_en[rsc_pkg::F_SLV_PRIO] == 1'b0
      |-> eff_slave_prio == !$past(pair_role_select_pin, 2))
      else $error("role pin not seen through two flops");
   a_sec_xc_off: assert property (s_xc_wr ##0 prio_path |-> prio_val == rsc_pkg::PRIO_OFF)
      else $error("secondary cross-connect priority not disabled");
   a_ofs_absorb_off: assert property (absorb_cfg == 2'h0 && !eff_absorb
      |=> applied_phase_ofs == $past(phase_ofs))
      else $error("phase offset not applied with absorption off");
   a_ofs_absorb_on: assert property (eff_absorb |=> applied_phase_ofs == 16'h0000)
      else $error("phase offset applied with absorption on");
endmodule : rsc_pair_chk
`default_nettype wire
